// file: include/ufc_pkg.sv
/*
 * Shared constants and types of the per-channel FIFO trigger and flow control block.
 * Assumes an APB master with 32-bit data and byte addresses in the low eight bits.
 */
`default_nettype none
package ufc_pkg;
	// Register byte offsets.
	localparam logic [7:0] ADDR_FIFO_CTRL = 8'h00;
	localparam logic [7:0] ADDR_FEATURE_CTRL = 8'h04;
	localparam logic [7:0] ADDR_ENH_FEATURE = 8'h08;
	localparam logic [7:0] ADDR_MODEM_CTRL = 8'h0c;
	localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
	localparam logic [7:0] ADDR_IRQ_SOURCE = 8'h14;
	localparam logic [7:0] ADDR_IRQ_IDENT = 8'h18;
	localparam logic [7:0] ADDR_RX_THRESHOLD = 8'h1c;
	localparam logic [7:0] ADDR_TX_THRESHOLD = 8'h20;
	localparam logic [7:0] ADDR_RESUME_ONE = 8'h24;
	localparam logic [7:0] ADDR_RESUME_TWO = 8'h28;
	localparam logic [7:0] ADDR_PAUSE_ONE = 8'h2c;
	localparam logic [7:0] ADDR_PAUSE_TWO = 8'h30;
	localparam logic [7:0] ADDR_FLOW_STATUS = 8'h34;
	// Values after reset.
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [1:0] PIN_RST = 2'h3;
	localparam logic [6:0] LVL_RST = 7'h01;
	// Field positions.
	localparam int FCR_ENABLE = 0;
	localparam int EFR_AUTO_CTS = 7;
	localparam int EFR_AUTO_RTS = 6;
	localparam int EFR_SPECIAL = 5;
	localparam int EFR_ENHANCED = 4;
	localparam int MCR_ANY = 5;
	localparam int MCR_PAIR = 2;
	localparam int MCR_RTS = 1;
	localparam int MCR_DTR = 0;
	localparam int IER_IN_GATE = 7;
	localparam int IER_OUT_GATE = 6;
	localparam int IER_PAUSE = 5;
	localparam int SRC_GATE = 5;
	localparam int IDENT_GATE = 5;
	localparam int IDENT_PAUSE = 4;
	// Levels in characters.
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [3:0][6:0] RX_SET_A = {7'h0e, 7'h08, 7'h04, 7'h01};
	localparam logic [3:0][6:0] RX_SET_B = {7'h1c, 7'h18, 7'h10, 7'h08};
	localparam logic [3:0][6:0] RX_SET_C = {7'h3c, 7'h38, 7'h10, 7'h08};
	localparam logic [3:0][6:0] TX_SET_B = {7'h1e, 7'h18, 7'h08, 7'h10};
	localparam logic [3:0][6:0] TX_SET_C = {7'h38, 7'h20, 7'h10, 7'h08};
	localparam logic [15:0][6:0] HYST = {7'h24, 7'h1c, 7'h14, 7'h0c, 7'h34, 7'h30, 7'h2c,
		7'h28, 7'h20, 7'h18, 7'h10, 7'h08, 7'h08, 7'h06, 7'h04, 7'h00};

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} ufc_apb_t;

	typedef struct packed {
		logic valid;
		logic [7:0] ch;
	} ufc_flow_t;

	typedef enum logic [1:0] {FS_IDLE, FS_FIRST, FS_SECOND} ufc_fs_t;

	typedef struct packed {
		logic [7:0] fifo_ctrl_reg, feature_ctrl_reg, enhanced_feature_reg, modem_ctrl_reg, irq_enable_reg, rxthr, txthr, r1, r2, p1, p2;
		logic src_gate, pflag, spec_src, paused, seq_p, seq_r, gate, sent_p, is_pause;
		ufc_fs_t fs;
		logic [1:0] s1, s2, s3;
		logic rts_n, dtr_n, irq_n, tx_allow, rx_store, pready, pslverr;
		logic [7:0] rx_char;
		logic [6:0] rx_threshold_reg, tx_threshold_reg;
		ufc_flow_t flow;
		logic [31:0] prdata;
	} ufc_state_t;
endpackage : ufc_pkg
`default_nettype wire

// file: rtl/ufc_flow.sv
/*
 * Trigger level selection, hardware and software flow control of one UART channel.
 * Assumes the receive FIFO, the shift register and the word length live outside, on pclk.
 */
`default_nettype none
// What this block does
// - Reset leaves FIFOs off, thresholds one.
// - Feature bits 7:6 pick threshold set.
// - Set A receive 1/4/8/14, transmit 1.
// - Set B receive 8/16/24/28, transmit 16/8/24/30.
// - Set C receive 8/16/56/60, transmit 8/16/32/56.
// - Set D uses software threshold registers.
// - Enhanced bits 7:6 enable auto gating.
// - Modem bit 2 picks the pin pair.
// - Sets A-C gate with neighbouring levels.
// - Set D gates at threshold plus/minus hysteresis.
// - Receive keeps storing whatever the FIFO level.
// - Outgoing gate pin change sets source bit 5.
// - Incoming gate input change sets source bit 5.
// - Incoming gate high stops transmit after character.
// - Enhanced bits 3:2 pick sent flow characters.
// - Enhanced bits 1:0 pick matched flow characters.
// - Resume on any character but a pause character when enabled.
// - Special character flags without halting, stored.
// - Pause character halts transmit, raises interrupt.
// - Resume character clears pause flag, resumes.
// - Send pause/resume characters by receive level.
// - Hysteresis decoded from feature bits 3:0.
// - Sent flow characters masked to word length.
module ufc_flow
	import ufc_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire ufc_pkg::ufc_apb_t apb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata,
	// Receive side of the channel.
	input wire logic [6:0] rx_level,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	output logic rx_store,
	output logic [7:0] rx_store_data,
	output logic [6:0] rx_trigger,
	// Transmit side of the channel.
	input wire logic [1:0] word_len,
	input wire logic flow_ready,
	output ufc_pkg::ufc_flow_t flow,
	output logic tx_allow,
	output logic [6:0] tx_trigger,
	// Modem pins and interrupt.
	input wire logic cts_n,
	input wire logic dsr_n,
	output logic rts_n,
	output logic dtr_n,
	output logic irq_n
);
	import ufc_pkg::*;

	ufc_state_t st;
	ufc_state_t next_st;
	logic [1:0] set;
	logic [7:0] hyst, hi_thr, lo_thr, lvl;
	logic hi, lo, wr, rd, mon, pause_hit, resume_hit, special, flow_char, seq, rx_en;
	logic [7:0] rdata;
	logic hit;

	function automatic logic [6:0] ufc_level(input logic [1:0] s, input logic [2:0] sel,
		input logic tx);
		logic [6:0] v;
		v = 7'h01;
		if (sel[2])
			v = FIFO_DEPTH;
		else if (tx && s == 2'h1)
			v = TX_SET_B[sel[1:0]];
		else if (tx && s == 2'h2)
			v = TX_SET_C[sel[1:0]];
		else if (!tx && s == 2'h0)
			v = RX_SET_A[sel[1:0]];
		else if (!tx && s == 2'h1)
			v = RX_SET_B[sel[1:0]];
		else if (!tx && s == 2'h2)
			v = RX_SET_C[sel[1:0]];
		return v;
	endfunction : ufc_level

	function automatic logic [7:0] ufc_mask(input logic [7:0] c, input logic [1:0] wl);
		logic [7:0] m;
		m = 8'hff >> (2'h3 - wl);
		return c & m;
	endfunction : ufc_mask

	always_comb
	begin
		next_st = st;
		set = st.feature_ctrl_reg[7:6];
		lvl = {1'b0, rx_level};
		// Threshold selection; a disabled FIFO behaves as a one character FIFO.
		if (!st.fifo_ctrl_reg[FCR_ENABLE])
		begin
			next_st.rx_threshold_reg = LVL_RST;
			next_st.tx_threshold_reg = LVL_RST;
		end
		else if (set == 2'h3)
		begin
			next_st.rx_threshold_reg = st.rxthr[6:0];
			next_st.tx_threshold_reg = st.txthr[6:0];
		end
		else
		begin
			next_st.rx_threshold_reg = ufc_level(set, {1'b0, st.fifo_ctrl_reg[7:6]}, 1'b0);
			next_st.tx_threshold_reg = ufc_level(set, {1'b0, st.fifo_ctrl_reg[5:4]}, 1'b1);
		end
		hyst = {1'b0, HYST[st.feature_ctrl_reg[3:0]]};
		if (set == 2'h3)
		begin
			hi_thr = {1'b0, st.rxthr[6:0]} + hyst;
			lo_thr = (st.rxthr[6:0] > hyst[6:0]) ? {1'b0, st.rxthr[6:0]} - hyst : 8'h00;
			lo = lvl < lo_thr;
		end
		else
		begin
			hi_thr = {1'b0, ufc_level(set, {1'b0, st.fifo_ctrl_reg[7:6]} + 3'h1, 1'b0)};
			lo_thr = (st.fifo_ctrl_reg[7:6] == 2'h0) ? 8'h00
				: {1'b0, ufc_level(set, {1'b0, st.fifo_ctrl_reg[7:6]} - 3'h1, 1'b0)};
			lo = lvl <= lo_thr;
		end
		hi = lvl >= hi_thr;
		if (hi)
			next_st.gate = 1'b1;
		else if (lo)
			next_st.gate = 1'b0;
		// Pin pair and auto gating; an unstarted pin stays high.
		next_st.s1 = {dsr_n, cts_n};
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		if (!st.modem_ctrl_reg[MCR_PAIR])
		begin
			next_st.rts_n = !st.modem_ctrl_reg[MCR_RTS] || (st.enhanced_feature_reg[EFR_AUTO_RTS] && st.gate);
			next_st.dtr_n = !st.modem_ctrl_reg[MCR_DTR];
			mon = st.s2[0];
		end
		else
		begin
			next_st.dtr_n = !st.modem_ctrl_reg[MCR_DTR] || (st.enhanced_feature_reg[EFR_AUTO_RTS] && st.gate);
			next_st.rts_n = !st.modem_ctrl_reg[MCR_RTS];
			mon = st.s2[1];
		end
		// APB access phase completes when the registered ready is high.
		wr = apb.psel && apb.penable && st.pready && apb.pwrite;
		rd = apb.psel && apb.penable && st.pready && !apb.pwrite;
		if (rd && apb.paddr == ADDR_IRQ_SOURCE)
			next_st.src_gate = 1'b0;
		if (rd && apb.paddr == ADDR_IRQ_IDENT && st.spec_src)
		begin
			next_st.pflag = 1'b0;
			next_st.spec_src = 1'b0;
		end
		// Gate interrupts are set after the clears so an event in a clear cycle wins.
		if (st.enhanced_feature_reg[EFR_ENHANCED] && st.irq_enable_reg[IER_OUT_GATE] && (st.modem_ctrl_reg[MCR_PAIR]
			? next_st.dtr_n != st.dtr_n : next_st.rts_n != st.rts_n))
			next_st.src_gate = 1'b1;
		if (st.enhanced_feature_reg[EFR_ENHANCED] && st.irq_enable_reg[IER_IN_GATE]
			&& (st.modem_ctrl_reg[MCR_PAIR] ? st.s2[1] != st.s3[1] : st.s2[0] != st.s3[0]))
			next_st.src_gate = 1'b1;
		// Receive matching of flow characters.
		rx_en = st.enhanced_feature_reg[1:0] != 2'h0;
		seq = st.enhanced_feature_reg[3:0] == 4'hf;
		unique case (st.enhanced_feature_reg[1:0])
			2'h2:
			begin
				pause_hit = rx_data == st.p1;
				resume_hit = rx_data == st.r1;
			end
			2'h1:
			begin
				pause_hit = rx_data == st.p2;
				resume_hit = rx_data == st.r2;
			end
			2'h3:
			begin
				pause_hit = seq ? st.seq_p && rx_data == st.p2
					: rx_data == st.p1 || rx_data == st.p2;
				resume_hit = seq ? st.seq_r && rx_data == st.r2
					: rx_data == st.r1 || rx_data == st.r2;
			end
			2'h0:
			begin
				pause_hit = 1'b0;
				resume_hit = 1'b0;
			end
		endcase
		pause_hit = pause_hit && rx_valid;
		resume_hit = resume_hit && rx_valid;
		special = rx_valid && st.enhanced_feature_reg[EFR_SPECIAL] && rx_data == st.p2;
		flow_char = rx_en && (pause_hit || resume_hit
			|| (seq && (rx_data == st.p1 || rx_data == st.r1)));
		next_st.rx_store = rx_valid && !flow_char;
		next_st.rx_char = rx_data;
		if (rx_valid)
		begin
			next_st.seq_p = seq && rx_data == st.p1;
			next_st.seq_r = seq && rx_data == st.r1;
		end
		if (pause_hit)
		begin
			next_st.paused = 1'b1;
			next_st.pflag = 1'b1;
			next_st.spec_src = 1'b0;
		end
		else if (rx_valid && st.paused && (resume_hit || st.modem_ctrl_reg[MCR_ANY]))
		begin
			next_st.paused = 1'b0;
			next_st.pflag = 1'b0;
		end
		else if (special)
		begin
			next_st.pflag = 1'b1;
			next_st.spec_src = !st.paused;
		end
		// The shift register samples tx_allow only between characters.
		next_st.tx_allow = !next_st.paused
			&& !(st.enhanced_feature_reg[EFR_AUTO_CTS] && mon);
		next_st.irq_n = !((st.pflag && st.irq_enable_reg[IER_PAUSE]) || st.src_gate);
		// Transmit side flow characters.
		unique case (st.fs)
			FS_IDLE:
			begin
				if (st.enhanced_feature_reg[3:2] == 2'h0)
					next_st.sent_p = 1'b0;
				else if (!st.sent_p && lvl >= {1'b0, st.rx_threshold_reg})
				begin
					next_st.sent_p = 1'b1;
					next_st.is_pause = 1'b1;
					next_st.fs = FS_FIRST;
				end
				else if (st.sent_p && lo)
				begin
					next_st.sent_p = 1'b0;
					next_st.is_pause = 1'b0;
					next_st.fs = FS_FIRST;
				end
			end
			FS_FIRST:
				if (st.flow.valid && flow_ready)
					next_st.fs = (st.enhanced_feature_reg[3:2] == 2'h3) ? FS_SECOND : FS_IDLE;
			FS_SECOND:
				if (st.flow.valid && flow_ready)
					next_st.fs = FS_IDLE;
		endcase
		next_st.flow.valid = next_st.fs != FS_IDLE;
		if (next_st.fs == FS_SECOND || st.enhanced_feature_reg[3:2] == 2'h1)
			next_st.flow.ch = ufc_mask(next_st.is_pause ? st.p2 : st.r2, word_len);
		else
			next_st.flow.ch = ufc_mask(next_st.is_pause ? st.p1 : st.r1, word_len);
		// Register file.
		hit = 1'b1;
		unique case (apb.paddr)
			ADDR_FIFO_CTRL: rdata = st.fifo_ctrl_reg;
			ADDR_FEATURE_CTRL: rdata = st.feature_ctrl_reg;
			ADDR_ENH_FEATURE: rdata = st.enhanced_feature_reg;
			ADDR_MODEM_CTRL: rdata = st.modem_ctrl_reg;
			ADDR_IRQ_ENABLE: rdata = st.irq_enable_reg;
			ADDR_IRQ_SOURCE: rdata = {2'h0, st.src_gate, 5'h00};
			ADDR_IRQ_IDENT: rdata = {2'h0, st.src_gate, st.pflag && st.irq_enable_reg[IER_PAUSE], 3'h0,
				!(st.src_gate || (st.pflag && st.irq_enable_reg[IER_PAUSE]))};
			ADDR_RX_THRESHOLD: rdata = st.rxthr;
			ADDR_TX_THRESHOLD: rdata = st.txthr;
			ADDR_RESUME_ONE: rdata = st.r1;
			ADDR_RESUME_TWO: rdata = st.r2;
			ADDR_PAUSE_ONE: rdata = st.p1;
			ADDR_PAUSE_TWO: rdata = st.p2;
			ADDR_FLOW_STATUS: rdata = {4'h0, mon, st.sent_p, st.gate, st.paused};
			default:
			begin
				rdata = 8'h00;
				hit = 1'b0;
			end
		endcase
		next_st.pready = apb.psel && !apb.penable;
		next_st.pslverr = apb.psel && !apb.penable && !hit;
		next_st.prdata = (apb.psel && !apb.penable && !apb.pwrite) ? {24'h0, rdata} : 32'h0;
		if (wr)
		begin
			unique case (apb.paddr)
				ADDR_FIFO_CTRL: next_st.fifo_ctrl_reg = apb.pwdata[7:0];
				ADDR_FEATURE_CTRL: next_st.feature_ctrl_reg = apb.pwdata[7:0];
				ADDR_ENH_FEATURE: next_st.enhanced_feature_reg = apb.pwdata[7:0];
				ADDR_MODEM_CTRL: next_st.modem_ctrl_reg = apb.pwdata[7:0];
				ADDR_IRQ_ENABLE: next_st.irq_enable_reg = apb.pwdata[7:0];
				ADDR_RX_THRESHOLD: next_st.rxthr = apb.pwdata[7:0];
				ADDR_TX_THRESHOLD: next_st.txthr = apb.pwdata[7:0];
				ADDR_RESUME_ONE: next_st.r1 = apb.pwdata[7:0];
				ADDR_RESUME_TWO: next_st.r2 = apb.pwdata[7:0];
				ADDR_PAUSE_ONE: next_st.p1 = apb.pwdata[7:0];
				ADDR_PAUSE_TWO: next_st.p2 = apb.pwdata[7:0];
				default: next_st.fifo_ctrl_reg = st.fifo_ctrl_reg;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st <= '0;
			st.fifo_ctrl_reg <= REG_RST;
			st.s1 <= PIN_RST;
			st.s2 <= PIN_RST;
			st.s3 <= PIN_RST;
			st.rts_n <= 1'b1;
			st.dtr_n <= 1'b1;
			st.irq_n <= 1'b1;
			st.tx_allow <= 1'b1;
			st.rx_threshold_reg <= LVL_RST;
			st.tx_threshold_reg <= LVL_RST;
			st.fs <= FS_IDLE;
		end
		else
			st <= next_st;
	end

	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign prdata = st.prdata;
	assign rx_store = st.rx_store;
	assign rx_store_data = st.rx_char;
	assign rx_trigger = st.rx_threshold_reg;
	assign tx_trigger = st.tx_threshold_reg;
	assign flow = st.flow;
	assign tx_allow = st.tx_allow;
	assign rts_n = st.rts_n;
	assign dtr_n = st.dtr_n;
	assign irq_n = st.irq_n;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	fifo_off_a: assert property (!st.fifo_ctrl_reg[0] |=> rx_trigger == 7'h01 && tx_trigger == 7'h01)
		else $error("disabled FIFO threshold not one");
	set_a_a: assert property (st.fifo_ctrl_reg[0] && st.feature_ctrl_reg[7:6] == 2'h0 && st.fifo_ctrl_reg[7:6] == 2'h3
		|=> rx_trigger == 7'h0e && tx_trigger == 7'h01)
		else $error("set A levels wrong");
	set_b_a: assert property (st.fifo_ctrl_reg[0] && st.feature_ctrl_reg[7:6] == 2'h1 && st.fifo_ctrl_reg[5:4] == 2'h3
		|=> tx_trigger == 7'h1e)
		else $error("set B transmit level wrong");
	set_c_a: assert property (st.fifo_ctrl_reg[0] && st.feature_ctrl_reg[7:6] == 2'h2 && st.fifo_ctrl_reg[7:6] == 2'h2
		|=> rx_trigger == 7'h38)
		else $error("set C receive level wrong");
	set_d_a: assert property (st.fifo_ctrl_reg[0] && st.feature_ctrl_reg[7:6] == 2'h3 && $stable(st.rxthr)
		|=> rx_trigger == $past(st.rxthr[6:0]))
		else $error("set D ignores software level");
	cts_stop_a: assert property (st.enhanced_feature_reg[7] && !st.modem_ctrl_reg[2] && st.s2[0] |=> !tx_allow)
		else $error("transmit not gated by input");
	rts_high_a: assert property (st.enhanced_feature_reg[6] && st.modem_ctrl_reg[1] && !st.modem_ctrl_reg[2] && hi
		|=> ##1 rts_n)
		else $error("request pin not raised");
	keep_rx_a: assert property (rx_valid && !flow_char |=> rx_store
		&& rx_store_data == $past(rx_data))
		else $error("received character dropped");
	pause_halt_a: assert property (pause_hit |=> !tx_allow && st.pflag)
		else $error("pause did not halt");
	resume_go_a: assert property (rx_valid && st.paused && resume_hit && !pause_hit
		|=> !st.paused && !st.pflag)
		else $error("resume did not clear pause");
	flow_mask_a: assert property (flow.valid && word_len == 2'h0 |-> flow.ch[7:5] == 3'h0)
		else $error("flow character not masked");
	gate_irq_a: assert property (st.enhanced_feature_reg[4] && st.irq_enable_reg[7] && !st.modem_ctrl_reg[2] && st.s2[0] != st.s3[0]
		|=> st.src_gate ##1 !irq_n)
		else $error("gate change not flagged");
	pause_cv: cover property (pause_hit ##[1:50] resume_hit);
	flow_cv: cover property (flow.valid && flow_ready ##1 flow.valid);
	rts_cv: cover property ($rose(rts_n) ##[1:200] $fell(rts_n));
endmodule : ufc_flow
`default_nettype wire

// file: testbench/ufc_flow_bench.sv
/*
 * Self-checking bench of the trigger and flow control block, with random trigger settings.
 * Assumes the package, the design and the remote partner are compiled first.
 */
`default_nettype none
module ufc_flow_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import ufc_pkg::*;
	logic pclk, presetn, pready, pslverr, rx_valid, rx_store, flow_ready, tx_allow, err;
	logic cts_n, dsr_n, rts_n, dtr_n, irq_n;
	logic [31:0] prdata, rd;
	logic [6:0] rx_level, rx_trigger, tx_trigger;
	logic [7:0] rx_data, rx_store_data, got_ch, n_got, fifo_ctrl_reg, rt, tt, g0, mk;
	logic [1:0] word_len;
	ufc_apb_t apb;
	ufc_flow_t flow;
	int miscompares = 0;
	int n_checks = 0;
	int n_store = 0;
	int n0;
	integer seed;

	ufc_flow dut_u (.pclk(pclk), .presetn(presetn), .apb(apb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata), .rx_level(rx_level), .rx_valid(rx_valid),
		.rx_data(rx_data), .rx_store(rx_store), .rx_store_data(rx_store_data),
		.rx_trigger(rx_trigger), .word_len(word_len), .flow_ready(flow_ready), .flow(flow),
		.tx_allow(tx_allow), .tx_trigger(tx_trigger), .cts_n(cts_n), .dsr_n(dsr_n),
		.rts_n(rts_n), .dtr_n(dtr_n), .irq_n(irq_n));
	ufc_remote rm_u (.pclk(pclk), .presetn(presetn), .flow(flow), .flow_ready(flow_ready),
		.got_ch(got_ch), .n_got(n_got), .rx_valid(rx_valid), .rx_data(rx_data),
		.cts_n(cts_n), .dsr_n(dsr_n));

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	always @(posedge pclk)
		if (rx_store === 1'b1)
			n_store <= n_store + 1;

	task automatic final_report(input logic hung);
		if (hung)
			miscompares++;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge pclk);
		apb <= '{1'b1, 1'b0, wr, a, {24'h000000, d}};
		@(posedge pclk);
		apb.penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		apb <= '0;
		if (i == 16)
			final_report(1'b1);
	endtask : bus

	function automatic logic [6:0] exp_rx(input logic [7:0] fc, fr, r);
		logic [6:0] t [12];
		t = '{7'h01, 7'h04, 7'h08, 7'h0e, 7'h08, 7'h10, 7'h18, 7'h1c, 7'h08, 7'h10, 7'h38, 7'h3c};
		return (fc[7:6] == 2'b11) ? r[6:0] : t[{fc[7:6], fr[7:6]}];
	endfunction : exp_rx

	function automatic logic [6:0] exp_tx(input logic [7:0] fc, fr, r);
		logic [6:0] t [12];
		t = '{7'h01, 7'h01, 7'h01, 7'h01, 7'h10, 7'h08, 7'h18, 7'h1e, 7'h08, 7'h10, 7'h20, 7'h38};
		return (fc[7:6] == 2'b11) ? r[6:0] : t[{fc[7:6], fr[5:4]}];
	endfunction : exp_tx

	// Walks the receive level through four values and samples the selected gate pin.
	task automatic walk(input logic [6:0] l0, l1, l2, l3, input logic [3:0] ex, input logic p);
		logic [6:0] lv [4];
		lv = '{l0, l1, l2, l3};
		foreach (lv[i])
		begin
			rx_level <= lv[i];
			repeat (4) @(posedge pclk);
			chk("gate pin", {31'h0, ex[3 - i]}, {31'h0, p ? dtr_n : rts_n});
		end
	endtask : walk

	initial
	begin
		repeat (40000) @(posedge pclk);
		final_report(1'b1);
	end

	initial
	begin
		seed = 63862;
		presetn = 1'b0;
		apb = '0;
		rx_level = 7'h00;
		word_len = 2'b11;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("reset pins", 32'h7, {29'h0, rts_n, dtr_n, irq_n});
		chk("reset trig", 32'h81, {18'h0, rx_trigger, tx_trigger});
		bus(1'b0, 8'h3c, 8'h00);
		chk("unmapped", 32'h1, {31'h0, err} | rd);
		for (int k = 0; k < 24; k++)
		begin
			fifo_ctrl_reg = 8'($random(seed)) | 8'h01;
			rt = 8'h01 + 8'({$random(seed)} % 64);
			tt = 8'h01 + 8'({$random(seed)} % 64);
			rx_level <= 7'({$random(seed)} % 65);
			word_len <= 2'($random(seed));
			bus(1'b1, ADDR_RX_THRESHOLD, rt);
			bus(1'b1, ADDR_TX_THRESHOLD, tt);
			bus(1'b1, ADDR_FIFO_CTRL, fifo_ctrl_reg);
			bus(1'b1, ADDR_FEATURE_CTRL, {k[1:0], 6'h00});
			repeat (2) @(posedge pclk);
			chk("rx trig", exp_rx({k[1:0], 6'h00}, fifo_ctrl_reg, rt), rx_trigger);
			chk("tx trig", exp_tx({k[1:0], 6'h00}, fifo_ctrl_reg, tt), tx_trigger);
			// With no flow control every character reaches the FIFO one cycle later.
			g0 = 8'($random(seed));
			rm_u.send(g0);
			@(posedge pclk);
			chk("store data", {1'b1, g0}, {rx_store, rx_store_data});
		end
		// The gate keeps its state between levels, so start the walks from empty.
		rx_level <= 7'h00;
		for (int p = 0; p < 2; p++)
		begin
			bus(1'b1, ADDR_FIFO_CTRL, 8'h41);
			bus(1'b1, ADDR_FEATURE_CTRL, 8'h00);
			bus(1'b1, ADDR_ENH_FEATURE, 8'h50);
			bus(1'b1, ADDR_IRQ_ENABLE, 8'h40);
			bus(1'b1, ADDR_MODEM_CTRL, p ? 8'h05 : 8'h02);
			walk(7'h07, 7'h08, 7'h02, 7'h01, 4'b0110, p[0]);
			chk("idle pin", 32'h1, {31'h0, p ? rts_n : dtr_n});
			bus(1'b0, ADDR_IRQ_SOURCE, 8'h00);
			chk("gate source", 32'h1, {31'h0, rd[5]});
		end
		bus(1'b1, ADDR_RX_THRESHOLD, 8'h14);
		bus(1'b1, ADDR_FEATURE_CTRL, 8'hc1);
		bus(1'b1, ADDR_MODEM_CTRL, 8'h02);
		walk(7'h17, 7'h18, 7'h10, 7'h0f, 4'b0110, 1'b0);
		bus(1'b1, ADDR_ENH_FEATURE, 8'h90);
		bus(1'b1, ADDR_IRQ_ENABLE, 8'hc0);
		// The walk left the source flag set; clear it so the input change is seen alone.
		bus(1'b0, ADDR_IRQ_SOURCE, 8'h00);
		chk("walk source", 32'h1, {31'h0, rd[5]});
		rm_u.hold(1'b1);
		repeat (6) @(posedge pclk);
		chk("cts stop", 32'h0, {30'h0, tx_allow, irq_n});
		bus(1'b0, ADDR_IRQ_SOURCE, 8'h00);
		chk("in gate source", 32'h1, {31'h0, rd[5]});
		rm_u.hold(1'b0);
		repeat (6) @(posedge pclk);
		chk("cts go", 32'h1, {31'h0, tx_allow});
		bus(1'b0, ADDR_IRQ_SOURCE, 8'h00);
		chk("in gate back", 32'h1, {31'h0, rd[5]});
		// Each write replaces the whole feature byte, so the two kinds never overlap.
		bus(1'b1, ADDR_ENH_FEATURE, 8'h02);
		bus(1'b1, ADDR_PAUSE_ONE, 8'h13);
		bus(1'b1, ADDR_RESUME_ONE, 8'h11);
		bus(1'b1, ADDR_IRQ_ENABLE, 8'h20);
		n0 = n_store;
		rm_u.send(8'h13);
		repeat (4) @(posedge pclk);
		chk("paused", 32'h0, {30'h0, tx_allow, irq_n});
		bus(1'b0, ADDR_IRQ_IDENT, 8'h00);
		chk("ident pause", 32'h1, {31'h0, rd[4]});
		rm_u.send(8'h11);
		repeat (4) @(posedge pclk);
		chk("resumed", 32'h3, {30'h0, tx_allow, irq_n});
		bus(1'b1, ADDR_MODEM_CTRL, 8'h20);
		rm_u.send(8'h13);
		rm_u.send(8'h41);
		repeat (4) @(posedge pclk);
		chk("any resume", 32'h1, {31'h0, tx_allow});
		chk("stored", n0 + 1, n_store);
		bus(1'b1, ADDR_FIFO_CTRL, 8'h41);
		bus(1'b1, ADDR_FEATURE_CTRL, 8'h00);
		bus(1'b1, ADDR_PAUSE_ONE, 8'hf3);
		bus(1'b1, ADDR_PAUSE_TWO, 8'hda);
		bus(1'b1, ADDR_RESUME_ONE, 8'he5);
		bus(1'b1, ADDR_RESUME_TWO, 8'hac);
		for (int m = 1; m < 4; m++)
		begin
			rx_level <= 7'h00;
			word_len <= 2'(m - 1);
			mk = 8'hff >> (4 - m);
			bus(1'b1, ADDR_ENH_FEATURE, {4'h0, m[1:0], 2'b00});
			g0 = n_got + ((m == 3) ? 8'h02 : 8'h01);
			rx_level <= 7'h04;
			repeat (16) @(posedge pclk);
			chk("pause sent", {g0, (m == 2 ? 8'hf3 : 8'hda) & mk}, {n_got, got_ch});
			g0 = g0 + ((m == 3) ? 8'h02 : 8'h01);
			rx_level <= 7'h01;
			repeat (16) @(posedge pclk);
			chk("resume sent", {g0, (m == 2 ? 8'he5 : 8'hac) & mk}, {n_got, got_ch});
		end
		// Paired characters count only when they arrive back to back.
		bus(1'b1, ADDR_ENH_FEATURE, 8'h0f);
		bus(1'b1, ADDR_MODEM_CTRL, 8'h00);
		rm_u.send(8'hf3);
		rm_u.send(8'h41);
		rm_u.send(8'hda);
		repeat (3) @(posedge pclk);
		chk("broken pair", 32'h1, {31'h0, tx_allow});
		rm_u.send(8'hf3);
		rm_u.send(8'hda);
		repeat (3) @(posedge pclk);
		chk("pair pause", 32'h0, {31'h0, tx_allow});
		rm_u.send(8'he5);
		repeat (3) @(posedge pclk);
		chk("half resume", 32'h0, {31'h0, tx_allow});
		rm_u.send(8'hac);
		repeat (3) @(posedge pclk);
		chk("pair resume", 32'h1, {31'h0, tx_allow});
		bus(1'b1, ADDR_ENH_FEATURE, 8'h20);
		rm_u.send(8'hda);
		@(posedge pclk);
		chk("special store", {1'b1, 8'hda}, {rx_store, rx_store_data});
		repeat (2) @(posedge pclk);
		chk("special flag", 32'h2, {30'h0, tx_allow, irq_n});
		bus(1'b0, ADDR_IRQ_IDENT, 8'h00);
		chk("special ident", 32'h1, {31'h0, rd[4]});
		repeat (2) @(posedge pclk);
		chk("special clear", 32'h1, {31'h0, irq_n});
		final_report(1'b0);
	end
endmodule : ufc_flow_bench
`default_nettype wire

// file: testbench/ufc_remote.sv
/*
 * Remote serial partner: sends received characters, takes flow characters, drives gate inputs.
 * Assumes its tasks are called right after a rising edge of pclk.
 */
`default_nettype none
module ufc_remote
	import ufc_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Flow characters from the block.
	input wire ufc_pkg::ufc_flow_t flow,
	output logic flow_ready,
	output logic [7:0] got_ch,
	output logic [7:0] n_got,
	// Received characters towards the block.
	output logic rx_valid,
	output logic [7:0] rx_data,
	// Gate inputs.
	output logic cts_n,
	output logic dsr_n
);
	logic [1:0] cnt;
	logic slow;

	initial
	begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		cts_n = 1'b0;
		dsr_n = 1'b0;
	end

	// Prompt and slow takes alternate, so the sender must hold its request.
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			flow_ready <= 1'b0;
			got_ch <= 8'h00;
			n_got <= 8'h00;
			cnt <= 2'h0;
			slow <= 1'b0;
		end
		else if (flow.valid && flow_ready)
		begin
			got_ch <= flow.ch;
			n_got <= n_got + 8'h01;
			flow_ready <= 1'b0;
			cnt <= 2'h0;
			slow <= ~slow;
		end
		else
		begin
			cnt <= flow.valid ? cnt + 2'h1 : 2'h0;
			flow_ready <= flow.valid && (!slow || cnt == 2'h3);
		end

	// The gate pins are ignored: a remote may keep sending. The line shows junk when idle.
	task automatic send(input logic [7:0] ch);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_data <= ch;
		@(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~ch;
	endtask : send

	task automatic hold(input logic v);
		cts_n <= v;
		dsr_n <= v;
	endtask : hold
endmodule : ufc_remote
`default_nettype wire
